// ### verilog/ptc_cfg.svh
// Constants for the transparent clock: timing, frame offsets, codes
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH

// ===================================================================
// Timing
`define PTC_CLK_HZ 10000000
`define PTC_NS_PER_S 1000000000
`define PTC_TS_STEP_NS (`PTC_NS_PER_S / `PTC_CLK_HZ)

// ===================================================================
// Buffering
`define PTC_FIFO_DEPTH 16

// ===================================================================
// Frame layout, byte counts from first byte of frame
`define PTC_ETH_TYPE_OFF 7'h0C
`define PTC_VLAN_LEN 7'h04
`define PTC_CNT_MAX 7'h7F
`define PTC_OFF_NONE 7'h7F
// Relative to the ethertype position
`define PTC_REL_TYPE_LO 7'h01
`define PTC_REL_PTP_L2 7'h02
`define PTC_REL_IP_VER 7'h02
`define PTC_REL_IP_PROTO 7'h0B
`define PTC_REL_UDP_DPORT_LO 7'h19
`define PTC_REL_UDP_CSUM_HI 7'h1C
`define PTC_REL_UDP_CSUM_LO 7'h1D
`define PTC_REL_PTP_UDP 7'h1E
// Relative to the PTP header start
`define PTC_PREL_MSGTYPE 7'h00
`define PTC_PREL_CORR_FIRST 7'h08
`define PTC_PREL_CORR_LAST 7'h0F

// ===================================================================
// Codes
`define PTC_TPID_VLAN 16'h8100
`define PTC_ETYPE_PTP 16'h88F7
`define PTC_ETYPE_IPV4 16'h0800
`define PTC_IP_VER_IHL 8'h45
`define PTC_IP_PROTO_UDP 8'h11
`define PTC_UDP_PTP_EVENT 16'h013F
`define PTC_MSG_SYNC 4'h0
`define PTC_MSG_DELAY_REQ 4'h1
`define PTC_CORR_FRAC_ZERO 16'h0000
`define PTC_BYTE_ZERO 8'h00

`endif

// ### verilog/ptc_pkg.sv
// Types shared by the transparent clock files
`default_nettype none

package ptc_pkg;

  // ===================================================================
  // One byte of a frame on the stream
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } ptc_beat_t;

  // ===================================================================
  // Egress correction states
  typedef enum logic [1:0] {
    EG_PASS = 2'b01,
    EG_CORR = 2'b10
  } ptc_eg_st_t;

endpackage

`default_nettype wire

// ### verilog/ptc_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module ptc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  // ===================================================================
  // Handshake and occupancy
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;
  assign rd_valid = (cnt_q != '0);
  assign rd_data = mem[rp_q];
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  // Pointers, count and registered ready
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      wr_ready <= 1'b1;
    end else begin
      wp_q <= push ? AW'(wp_q + 1'b1) : wp_q;
      rp_q <= pop ? AW'(rp_q + 1'b1) : rp_q;
      cnt_q <= cnt_d;
      wr_ready <= (cnt_d != FULL); // Back-pressure reaches source
    end
  end

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= wr_data;
    end
  end

endmodule // ptc_fifo

`default_nettype wire

// ### verilog/ptc_top.sv
// End-to-end transparent clock: parses PTP frames, adds residency
// How it works
// [R1] Master sends Sync, keeps t1
// [R2] Slave stamps Sync arrival as t2
// [R3] One-step: t1 rides inside Sync
// [R4] Two-step: t1 follows in Follow_Up
// [R5] Slave sends Delay_Req, keeps t3
// [R6] Master stamps Delay_Req arrival as t4
// [R7] Master returns t4 in Delay_Resp
// [R8] Offset is half of path differences
// [R9] Path delay is half of sum
// [R10] Sync/Delay_Req correction gains residency time
// [R11] Only forwards; never master nor slave
// [R12] Residency includes switching and radio delay
// [R13] Hardware timestamps at ingress and egress
// [R14] Accept PTP over Ethernet and UDP/IPv4
// [R15] Accept tagged and untagged frames
// [R16] Boundary mode: untagged multicast Ethernet only
// [R17] PTP should get highest queue priority; here all frames share one FIFO, with no priority
// [R18] Residency is egress minus ingress stamp
// [R19] Residency added to existing correction
`timescale 1ns/100ps
`default_nettype none
`include "ptc_cfg.svh"

module ptc_top
  import ptc_pkg::*;
#(
  parameter int FIFO_DEPTH = `PTC_FIFO_DEPTH,
  parameter int TS_W = 48
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic bc_mode,
  input wire logic [31:0] radio_delay_ns,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  input wire logic in_valid,
  output logic in_ready,
  output logic [7:0] out_data,
  output logic out_last,
  output logic out_valid,
  input wire logic out_ready
);
  // Time base advance per clock, in ns
  localparam logic [TS_W-1:0] TS_STEP = TS_W'(`PTC_TS_STEP_NS);

  // ===================================================================
  // Free-running hardware time base in ns
  logic [TS_W-1:0] tod_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) tod_q <= '0;
    else tod_q <= tod_q + TS_STEP; // [R13]
  end

  // ===================================================================
  // Ingress side: FIFO fill and header parse
  ptc_beat_t in_beat;
  ptc_beat_t fifo_beat;
  logic fifo_valid;
  logic pop;
  logic in_fire;

  // Beat packing and ingress handshake
  assign in_beat = '{last: in_last, data: in_data};
  assign in_fire = in_valid && in_ready;

  // Cut-through byte buffer between ingress and egress
  ptc_fifo #(
    .WIDTH($bits(ptc_beat_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .wr_data(in_beat),
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .rd_data(fifo_beat),
    .rd_valid(fifo_valid),
    .rd_ready(pop)
  );

  logic [6:0] ic_q;
  logic [6:0] e_q;
  logic [6:0] ptp_off_q;
  logic [7:0] hi_q;
  logic vlan_q;
  logic mcast_q;
  logic l2_q;
  logic ip_q;
  logic ipok_q;
  logic udp_q;
  logic event_q;
  logic corr_done_q;
  logic ing_end_q;
  logic [63:0] corr_q;
  logic [TS_W-1:0] ing_ts_q;

  // Ingress byte position decode
  logic [6:0] rel_i;
  logic [6:0] prel_i;
  logic [15:0] typ_w;
  logic sof_i;
  logic at_type;
  logic is_tpid;
  logic is_l2ptp;
  logic is_ipv4;
  logic ip_ver_ok;
  logic ip_udp_ok;
  logic udp_port_ok;
  logic at_msg;
  logic msg_event;
  logic in_corr;

  assign rel_i = ic_q - e_q;
  assign prel_i = ic_q - ptp_off_q;
  assign typ_w = {hi_q, in_data};
  assign sof_i = in_fire && (ic_q == '0);
  assign at_type = in_fire && (rel_i == `PTC_REL_TYPE_LO);
  assign is_tpid = at_type && !vlan_q && (typ_w == `PTC_TPID_VLAN); // [R15]
  assign is_l2ptp = at_type && (typ_w == `PTC_ETYPE_PTP); // [R14]
  assign is_ipv4 = at_type && (typ_w == `PTC_ETYPE_IPV4); // [R14]
  assign ip_ver_ok = (in_data == `PTC_IP_VER_IHL);
  assign ip_udp_ok = ipok_q && (in_data == `PTC_IP_PROTO_UDP);
  assign udp_port_ok = ipok_q && (typ_w == `PTC_UDP_PTP_EVENT);
  assign at_msg = in_fire && (l2_q || udp_q) && (prel_i == `PTC_PREL_MSGTYPE);
  // Sync corrected whether t1 rides inside it or follows later;
  // Follow_Up and Delay_Resp are not event messages and keep their correction untouched
  assign msg_event = (in_data[3:0] == `PTC_MSG_SYNC) ||
                     (in_data[3:0] == `PTC_MSG_DELAY_REQ); // [R3] [R4] [R10]
  assign in_corr = in_fire && event_q && (prel_i >= `PTC_PREL_CORR_FIRST) &&
                   (prel_i <= `PTC_PREL_CORR_LAST);

  // Ingress byte counter, previous byte and ingress stamp
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ic_q <= '0;
      hi_q <= '0;
      ing_ts_q <= '0;
    end else if (in_fire) begin
      ic_q <= in_last ? '0 : ((ic_q == `PTC_CNT_MAX) ? ic_q : ic_q + 7'h01);
      hi_q <= in_data;
      if (sof_i) ing_ts_q <= tod_q; // [R13] [R18]
    end
  end

  // Encapsulation flags, cleared at each new frame; group bit loaded from its first byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      e_q <= `PTC_ETH_TYPE_OFF;
      vlan_q <= 1'b0;
      mcast_q <= 1'b0;
      l2_q <= 1'b0;
      ip_q <= 1'b0;
    end else if (sof_i) begin
      e_q <= `PTC_ETH_TYPE_OFF;
      vlan_q <= 1'b0;
      mcast_q <= in_data[0]; // Group bit of destination address
      l2_q <= 1'b0;
      ip_q <= 1'b0;
    end else begin
      if (is_tpid) e_q <= e_q + `PTC_VLAN_LEN; // [R15]
      if (is_tpid) vlan_q <= 1'b1;
      if (is_l2ptp) l2_q <= 1'b1;
      if (is_ipv4) ip_q <= 1'b1;
    end
  end

  // IPv4/UDP checks and PTP header position
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ipok_q <= 1'b0;
      udp_q <= 1'b0;
      ptp_off_q <= `PTC_OFF_NONE;
    end else if (sof_i) begin
      ipok_q <= 1'b0;
      udp_q <= 1'b0;
      ptp_off_q <= `PTC_OFF_NONE;
    end else if (in_fire) begin
      if (is_l2ptp) ptp_off_q <= e_q + `PTC_REL_PTP_L2; // [R14]
      if (ip_q && rel_i == `PTC_REL_IP_VER) ipok_q <= ip_ver_ok;
      if (ip_q && rel_i == `PTC_REL_IP_PROTO) ipok_q <= ip_udp_ok;
      if (ip_q && rel_i == `PTC_REL_UDP_DPORT_LO && udp_port_ok) begin
        udp_q <= 1'b1; // [R14]
        ptp_off_q <= e_q + `PTC_REL_PTP_UDP;
      end
    end
  end

  // Message type and arriving correction capture
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      event_q <= 1'b0;
      corr_done_q <= 1'b0;
      corr_q <= '0;
    end else if (sof_i) begin
      event_q <= 1'b0;
      corr_done_q <= 1'b0;
    end else begin
      if (at_msg) event_q <= msg_event; // [R10]
      if (in_corr) corr_q <= {corr_q[55:0], in_data}; // [R19]
      if (in_corr && prel_i == `PTC_PREL_CORR_LAST) corr_done_q <= 1'b1;
    end
  end

  // Frame end seen on ingress; a new end wins over the clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) ing_end_q <= 1'b0;
    else if (in_fire && in_last) ing_end_q <= 1'b1;
    else if (sof_i) ing_end_q <= 1'b0;
  end

  // ===================================================================
  // Egress side: drain, stamp and rewrite correction
  ptc_eg_st_t eg_st_q;
  logic [6:0] oc_q;
  logic [TS_W-1:0] eg_ts_q;
  logic [63:0] ncorr_q;
  logic [6:0] orel_e;
  logic [6:0] prel_e;
  logic at_corr;
  logic bc_ok;
  logic apply;
  logic stall;
  logic [TS_W-1:0] resid;
  logic [63:0] corr_sum;
  logic csum_zero;
  logic [7:0] eg_byte;

  // Egress reuses the ingress parse state; safe since a PTP frame outgrows
  // the FIFO, so its correction bytes leave before the next frame starts
  assign orel_e = oc_q - e_q;
  assign prel_e = oc_q - ptp_off_q;
  assign at_corr = (eg_st_q == EG_PASS) && event_q &&
                   (prel_e == `PTC_PREL_CORR_FIRST);
  assign bc_ok = !bc_mode || (l2_q && !vlan_q && mcast_q); // [R16]
  assign apply = at_corr && corr_done_q && bc_ok;
  // Wait for all eight arriving correction bytes unless the frame is cut short
  assign stall = at_corr && !corr_done_q && !ing_end_q;
  assign pop = fifo_valid && (!out_valid || out_ready) && !stall;
  // Switching delay from stamps plus the radio hop delay
  assign resid = eg_ts_q - ing_ts_q + TS_W'(radio_delay_ns); // [R12] [R18]
  assign corr_sum = corr_q + {resid, `PTC_CORR_FRAC_ZERO}; // [R10] [R19]
  // Zeroed UDP checksum stays valid after the payload edit
  assign csum_zero = udp_q && ((orel_e == `PTC_REL_UDP_CSUM_HI) ||
                               (orel_e == `PTC_REL_UDP_CSUM_LO));
  assign eg_byte = apply ? corr_sum[63:56] :
                   (eg_st_q == EG_CORR) ? ncorr_q[63:56] :
                   csum_zero ? `PTC_BYTE_ZERO : fifo_beat.data; // [R11]

  // Egress byte counter and egress stamp
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oc_q <= '0;
      eg_ts_q <= '0;
    end else if (pop) begin
      oc_q <= fifo_beat.last ? '0 :
              ((oc_q == `PTC_CNT_MAX) ? oc_q : oc_q + 7'h01);
      if (oc_q == '0) eg_ts_q <= tod_q; // [R13] [R18]
    end
  end

  // Correction rewrite sequencing, most significant byte first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eg_st_q <= EG_PASS;
      ncorr_q <= '0;
    end else if (pop) begin
      case (eg_st_q)
        EG_PASS: begin
          if (apply) begin
            eg_st_q <= EG_CORR; // [R10]
            ncorr_q <= {corr_sum[55:0], `PTC_BYTE_ZERO};
          end
        end
        EG_CORR: begin
          ncorr_q <= {ncorr_q[55:0], `PTC_BYTE_ZERO};
          if (prel_e == `PTC_PREL_CORR_LAST || fifo_beat.last) eg_st_q <= EG_PASS;
        end
        default: eg_st_q <= EG_PASS;
      endcase
    end
  end

  // Output register stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
      out_last <= 1'b0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= eg_byte;
      out_last <= fifo_beat.last;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule // ptc_top

`default_nettype wire

// ### test/ptc_top_properties.sv
// Port checker for the transparent clock
`timescale 1ns/100ps
`default_nettype none

module ptc_top_properties
  import ptc_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int TS_W = 48
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_last,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_valid,
  input wire logic out_ready
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] frm_q;
  logic [7:0] frm_d;

  // Bytes and frames held inside the block
  assign cnt_d = cnt_q + {7'h00, in_valid && in_ready} - {7'h00, out_valid && out_ready};
  assign frm_d = frm_q + {7'h00, in_valid && in_ready && in_last}
    - {7'h00, out_valid && out_ready && out_last};

  // Occupancy counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
      frm_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
      frm_q <= frm_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // ==================================================================
  // Stream properties
  property p_rst_idle;
    $rose(resetn) |-> !out_valid && in_ready && !out_last && out_data == 8'h00;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("bad idle");
  property p_hold_valid;
    out_valid && !out_ready |=> out_valid;
  endproperty
  a_hold_valid: assert property (p_hold_valid) else $error("valid dropped");
  property p_hold_data;
    out_valid && !out_ready |=> $stable(out_data) && $stable(out_last);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("data moved");
  property p_no_phantom;
    out_valid |-> cnt_q != 8'h00;
  endproperty
  a_no_phantom: assert property (p_no_phantom) else $error("byte from nowhere");
  property p_min_lat;
    in_valid && in_ready && cnt_q == 8'h00 |=> !out_valid;
  endproperty
  a_min_lat: assert property (p_min_lat) else $error("too early");
  property p_room;
    cnt_q < FIFO_DEPTH - 2 |-> in_ready;
  endproperty
  a_room: assert property (p_room) else $error("stall with room");
  property p_ready_fall;
    $fell(in_ready) |-> cnt_q >= FIFO_DEPTH;
  endproperty
  a_ready_fall: assert property (p_ready_fall) else $error("early stall");
  property p_frame;
    out_valid && out_last |-> frm_q != 8'h00;
  endproperty
  a_frame: assert property (p_frame) else $error("extra frame end");
endmodule // ptc_top_properties

bind ptc_top ptc_top_properties #(.FIFO_DEPTH(FIFO_DEPTH), .TS_W(TS_W)) ptc_top_properties_inst (
  .clk(clk), .resetn(resetn), .in_last(in_last), .in_valid(in_valid), .in_ready(in_ready),
  .out_data(out_data), .out_last(out_last), .out_valid(out_valid), .out_ready(out_ready));
`default_nettype wire

// ### test/ptc_peer.sv
// Downstream clock node: takes egress bytes, stalls at random
`timescale 1ns/100ps
`default_nettype none

module ptc_peer
  import ptc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [1:0] stall_lvl,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_valid,
  output logic out_ready
);
  integer seed = 32'h62207F33;
  ptc_beat_t rx_q[$];
  time tout_q[$];
  ptc_beat_t bt;
  logic tk = 1'b0;
  logic sof = 1'b1;

  initial out_ready = 1'b0;

  // Ready drawn after each edge
  always @(posedge clk) begin
    #1 out_ready <= resetn && (($random(seed) & 3) >= stall_lvl);
  end

  // Sample the handshake before the edge
  always @(negedge clk) begin
    tk = out_valid === 1'b1 && out_ready;
    bt = '{out_last, out_data};
  end

  // Store bytes, stamp frame arrival
  always @(posedge clk) begin
    if (tk && resetn) begin
      rx_q.push_back(bt);
      if (sof) tout_q.push_back($time);
      sof = bt.last;
    end
  end
endmodule // ptc_peer
`default_nettype wire

// ### test/test_ptc_top.sv
// Self-checking bench for the transparent clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end

module test_ptc_top
  import ptc_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic bc_mode = 1'b0;
  logic in_last = 1'b0;
  logic in_valid = 1'b0;
  logic saw_full = 1'b0;
  logic [31:0] radio = 32'h0;
  logic [7:0] in_data = 8'h00;
  logic [1:0] lvl = 2'h0;
  logic [7:0] out_data;
  logic out_last, out_valid, out_ready, in_ready;
  integer seed = 32'h62207F32;
  int err_total = 0;
  int checked = 0;
  int g;
  logic [7:0] fr[$];
  logic [7:0] exp_q[$];
  int len_q[$];
  int ofs_q[$];
  logic [1:0] fl_q[$];
  time tin_q[$];
  longint lat_q[$];

  always #50 clk = ~clk;
  always @(negedge clk) if (resetn && !in_ready) saw_full = 1'b1;

  ptc_top #(.FIFO_DEPTH(16), .TS_W(48)) ptc_top_inst (.clk(clk), .resetn(resetn),
    .bc_mode(bc_mode), .radio_delay_ns(radio), .in_data(in_data), .in_last(in_last),
    .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data), .out_last(out_last),
    .out_valid(out_valid), .out_ready(out_ready));
  ptc_peer ptc_peer_inst (.clk(clk), .resetn(resetn), .stall_lvl(lvl), .out_data(out_data),
    .out_last(out_last), .out_valid(out_valid), .out_ready(out_ready));

  // Slave clock arithmetic from the four stamps
  function automatic longint off_f(input longint t1, t2, t3, t4);
    return ((t2 - t1) - (t4 - t3)) / 2;
  endfunction

  function automatic longint mpd_f(input longint t1, t2, t3, t4);
    return ((t2 - t1) + (t4 - t3)) / 2;
  endfunction

  // Build one frame and its expectation
  task mk(input bit tag, input bit udp, input bit bc, input logic [3:0] mt, input int cut);
    int p, i, b;
    bit pv;
    bit cv;
    fr.delete();
    for (i = 0; i < 12; i++) fr.push_back($random(seed));
    if (bc) fr[0] = fr[0] | {7'h00, fr[1][0]};
    pv = !udp || !(fr[2][0] && fr[2][1]);
    if (tag) fr = {fr, 8'h81, 8'h00, 8'h00, 8'h05};
    if (udp) begin
      fr = {fr, 8'h08, 8'h00};
      b = fr.size();
      for (i = 0; i < 28; i++) fr.push_back($random(seed));
      fr[b] = 8'h45;
      fr[b + 9] = 8'h11;
      fr[b + 22] = 8'h01;
      fr[b + 23] = pv ? 8'h3F : 8'h40;
    end else begin
      fr = {fr, 8'h88, 8'hF7};
    end
    p = fr.size();
    for (i = 0; i < 44; i++) fr.push_back($random(seed));
    fr[p] = {4'h0, mt};
    if (cut > 0) fr = fr[0:cut - 1];
    ofs_q.push_back(p);
    cv = mt < 2 && pv && cut == 0 && !(bc && (tag || udp || !fr[0][0]));
    fl_q.push_back({udp && pv, cv});
    len_q.push_back(fr.size());
    exp_q = {exp_q, fr};
  endtask

  // Offer the frame byte by byte
  task send();
    int i;
    logic ok;
    for (i = 0; i < fr.size(); i++) begin
      in_valid <= 1'b1;
      in_data <= fr[i];
      in_last <= (i == fr.size() - 1);
      ok = 1'b0;
      while (ok !== 1'b1) begin
        @(negedge clk);
        ok = in_ready;
        @(posedge clk);
      end
      if (i == 0) tin_q.push_back($time);
      #1;
    end
  endtask

  // Compare one forwarded frame
  task chk();
    int i, n, p;
    logic [1:0] f;
    ptc_beat_t b;
    logic [7:0] e;
    logic [63:0] o, nw, d, r;
    time ti, to;
    n = len_q.pop_front();
    p = ofs_q.pop_front();
    f = fl_q.pop_front();
    ti = tin_q.pop_front();
    to = ptc_peer_inst.tout_q.pop_front();
    for (i = 0; i < n; i++) begin
      b = ptc_peer_inst.rx_q.pop_front();
      e = exp_q.pop_front();
      `CHK(b.last, i == n - 1)
      if (f[0] && i >= p + 8 && i < p + 16) begin
        o = {o[55:0], e};
        nw = {nw[55:0], b.data};
      end else `CHK(b.data, (f[1] && (i == p - 2 || i == p - 1)) ? 8'h00 : e)
    end
    if (f[0]) begin
      d = nw - o;
      r = d >> 16;
      `CHK(d[15:0], 16'h0000)
      `CHK(r > radio && (r - radio) % 100 == 0 && r - radio <= to - ti, 1'b1)
      lat_q.push_back(to - ti - (r - radio));
    end
  endtask

  // Four frames back to back, then drain and check
  task grp(input int gi);
    int j, k;
    bc_mode <= gi[0];
    radio <= $random(seed) & 32'h000FFFFF;
    lvl <= gi[1] ? 2'h3 : 2'h0;
    // Only PTP traffic is offered, so it never waits behind other frames
    for (j = 0; j < 4; j++) begin
      k = $random(seed);
      mk(k[0], k[1], gi[0], {j[1], 2'b00, j[0]}, gi == 0 ? (j == 0 ? 1 : j == 1 ? 20 : 0) : 0);
      send();
    end
    in_valid <= 1'b0;
    in_data <= ~in_data;
    for (k = 0; k < 4000 && ptc_peer_inst.rx_q.size() < exp_q.size(); k++) @(posedge clk);
    if (ptc_peer_inst.rx_q.size() < exp_q.size()) begin
      err_total++;
      g = 16;
    end else begin
      while (len_q.size() > 0) chk();
      // Slave view of the Sync and Delay_Req pair, residency removed
      if (lat_q.size() == 2) begin
        `CHK(mpd_f(0, lat_q[0], 0, lat_q[1]) >= 64'h64, 1'b1)
        if (!gi[1]) begin
          `CHK(off_f(0, lat_q[0], 0, lat_q[1]), 64'h0)
          `CHK(mpd_f(0, lat_q[0], 0, lat_q[1]), 64'h64)
        end
      end
    end
    lat_q.delete();
    @(posedge clk);
    #1;
  endtask

  task print_verdict();
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    for (g = 0; g < 16; g++) grp(g);
    `CHK(saw_full, 1'b1)
    print_verdict();
  end

  // Watchdog
  initial begin
    #(100 * 60000);
    err_total++;
    print_verdict();
  end
endmodule // test_ptc_top
`default_nettype wire
